// ### common/sse_defines.vh
// Constants for the two sequencer stack entries: offsets, field positions, resets.
// Assumes inclusion by bare name from the design files.
`ifndef SSE_DEFINES_VH
`define SSE_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define SSE_OFF_ENTRY27 6'h3B
`define SSE_OFF_ENTRY28 6'h3C

// ****************************************
// Field positions
// ****************************************
`define SSE_DIR_BIT     15
`define SSE_ADDR_HI     14
`define SSE_ADDR_LO     9
`define SSE_RET_BIT     8
`define SSE_CHB_HI      7
`define SSE_CHB_LO      4
`define SSE_CHA_HI      3
`define SSE_CHA_LO      0

// ****************************************
// Reset values
// ****************************************
`define SSE_RST_ENTRY27 16'h7600
`define SSE_RST_ENTRY28 16'h7800

`endif

// ### hw/sse_entry.v
// One sequencer stack entry: holds the writable fields, fixed address field.
// Assumes a one-cycle write strobe from the enclosing register decoder.
`timescale 1ns/1ps
`default_nettype none
`include "sse_defines.vh"

module sse_entry #(
    parameter [15:0] RESET_WORD = `SSE_RST_ENTRY27
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        nrst,
    // Write port
    input  wire        wr_en,
    input  wire [15:0] wr_data,
    // Stored word
    output wire [15:0] word
);

    reg        dir_bit;
    reg        ret_bit;
    reg [3:0]  chb;
    reg [3:0]  cha;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dir_bit <= RESET_WORD[`SSE_DIR_BIT];
            ret_bit <= RESET_WORD[`SSE_RET_BIT];
            chb     <= RESET_WORD[`SSE_CHB_HI:`SSE_CHB_LO];
            cha     <= RESET_WORD[`SSE_CHA_HI:`SSE_CHA_LO];
        end else if (wr_en) begin
            dir_bit <= wr_data[`SSE_DIR_BIT];
            ret_bit <= wr_data[`SSE_RET_BIT];
            chb     <= wr_data[`SSE_CHB_HI:`SSE_CHB_LO];
            cha     <= wr_data[`SSE_CHA_HI:`SSE_CHA_LO];
        end
    end

    // The address field identifies the entry itself, so it is held constant.
    assign word = {dir_bit, RESET_WORD[`SSE_ADDR_HI:`SSE_ADDR_LO], ret_bit, chb, cha};

endmodule // sse_entry

`default_nettype wire

// ### hw/sse_stack.v
// Behaviour
// - Bit 15 of an entry word selects read (0) or write (1) access and is stored as written.
// - Bits 14-9 hold the entry's own address, 111011b for entry 27 and 111100b for entry 28.
// - With the return bit clear the sequencer moves to the next entry when a conversion ends; from entry 28 this block wraps to entry 27 instead.
// - With the return bit set the sequencer jumps to the first entry when a conversion ends.
// - Bits 7-4 pick converter B's channel for the active entry, read-write, reset zero.
// - Bits 3-0 pick converter A's channel for the active entry, read-write, reset zero.
// - Entry 28 sits at offset 0x3C and resets to 0x7800.
//
// Holds stack entries 27 and 28 and the step logic between them.
// Assumes conv_done pulses one cycle on the same clock when a conversion ends.
// Assumes the register port strobes are one cycle wide and never high together.
// The first stack entry lies outside this block, so a return is reported on
// return_to_first while the local index wraps to entry 27.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sse_defines.vh"

module sse_stack (
    // Clock and reset
    input  wire        core_clk,
    input  wire        nrst,
    // Register port
    input  wire [5:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Sequencer
    input  wire        conv_done,
    output reg         active_entry,
    output reg         return_to_first,
    output reg  [3:0]  converter_one_channel_pick,
    output reg  [3:0]  converter_two_channel_pick
);

    // ****************************************
    // Helper functions
    // ****************************************
    // Offset match, shared by the write enables and the read mux.
    function sse_hit;
        input [5:0] addr;
        input [5:0] offset;
        begin
            sse_hit = (addr == offset);
        end
    endfunction

    // Word of entry 27 or 28, chosen by the entry index.
    function [15:0] sse_pick_word;
        input        sel;
        input [15:0] w27;
        input [15:0] w28;
        begin
            if (sel) begin
                sse_pick_word = w28;
            end else begin
                sse_pick_word = w27;
            end
        end
    endfunction

    // Return control bit of an entry word.
    function sse_ret;
        input [15:0] entry_word;
        begin
            sse_ret = entry_word[`SSE_RET_BIT];
        end
    endfunction

    // Index entered when a conversion ends: 27 on a return, otherwise the other entry.
    function sse_step;
        input cur_entry;
        input ret_bit;
        begin
            if (ret_bit) begin
                sse_step = 1'b0;
            end else begin
                sse_step = ~cur_entry;
            end
        end
    endfunction

    // Converter A channel field of an entry word.
    function [3:0] sse_cha;
        input [15:0] entry_word;
        begin
            sse_cha = entry_word[`SSE_CHA_HI:`SSE_CHA_LO];
        end
    endfunction

    // Converter B channel field of an entry word.
    function [3:0] sse_chb;
        input [15:0] entry_word;
        begin
            sse_chb = entry_word[`SSE_CHB_HI:`SSE_CHB_LO];
        end
    endfunction

    // ****************************************
    // Entry storage
    // ****************************************
    // Writes and reads share one offset match, so they can never disagree about
    // which entry an offset means.
    wire [15:0] word27;
    wire [15:0] word28;
    wire        wr27 = reg_wr && sse_hit(reg_addr, `SSE_OFF_ENTRY27);
    wire        wr28 = reg_wr && sse_hit(reg_addr, `SSE_OFF_ENTRY28);

    sse_entry #(.RESET_WORD(`SSE_RST_ENTRY27)) u_entry27 (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr_en    (wr27),
        .wr_data  (reg_wdata),
        .word     (word27)
    );

    sse_entry #(.RESET_WORD(`SSE_RST_ENTRY28)) u_entry28 (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr_en    (wr28),
        .wr_data  (reg_wdata),
        .word     (word28)
    );

    // ****************************************
    // Read port
    // ****************************************
    // Unmapped offsets and cycles without a read strobe give zero, so the data
    // stand for exactly one cycle and a host may merge several slaves safely.
    reg  [15:0] next_reg_rdata;

    always @* begin
        next_reg_rdata = 16'h0000;
        if (reg_rd) begin
            if (sse_hit(reg_addr, `SSE_OFF_ENTRY27)) begin
                next_reg_rdata = word27;
            end else if (sse_hit(reg_addr, `SSE_OFF_ENTRY28)) begin
                next_reg_rdata = word28;
            end
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ****************************************
    // Stepping
    // ****************************************
    // Active entry 0 is entry 27, 1 is entry 28. A set return bit reports a jump to
    // the first stack entry, which lies outside this block; locally we wrap to 27.
    // Advancing past entry 28 wraps to 27 as well, since entry 29 is not held here.
    reg         next_active_entry;
    reg         next_return_to_first;
    reg  [3:0]  next_pick_one;
    reg  [3:0]  next_pick_two;
    reg  [15:0] cur_word;
    reg         cur_ret;
    reg  [15:0] entered_word;

    always @* begin
        cur_word             = sse_pick_word(active_entry, word27, word28);
        cur_ret              = sse_ret(cur_word);
        next_active_entry    = active_entry;
        next_return_to_first = 1'b0;
        entered_word         = cur_word;
        next_pick_one        = converter_one_channel_pick;
        next_pick_two        = converter_two_channel_pick;
        if (conv_done) begin
            next_active_entry    = sse_step(active_entry, cur_ret);
            next_return_to_first = cur_ret;
            entered_word         = sse_pick_word(next_active_entry, word27, word28);
            // Picks follow the entry being entered, so a write during a conversion waits.
            next_pick_one        = sse_cha(entered_word);
            next_pick_two        = sse_chb(entered_word);
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    // Each output has a flop of its own, so no sequencer output ever carries a
    // combinational glitch from a register write.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            active_entry <= 1'b0;
        end else begin
            active_entry <= next_active_entry;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            return_to_first <= 1'b0;
        end else begin
            return_to_first <= next_return_to_first;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            converter_one_channel_pick <= 4'h0;
        end else begin
            converter_one_channel_pick <= next_pick_one;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            converter_two_channel_pick <= 4'h0;
        end else begin
            converter_two_channel_pick <= next_pick_two;
        end
    end

endmodule // sse_stack

`default_nettype wire

// ### verification/sse_chk.sv
// Port checker for the stack entries.
// Assumes a bind onto sse_stack.
`timescale 1ns/1ps
`default_nettype none
module sse_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // Inputs
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic        conv_done,
    input wire logic [5:0]  reg_addr,
    // Outputs
    input wire logic [15:0] reg_rdata,
    input wire logic        active_entry,
    input wire logic        return_to_first,
    input wire logic [3:0]  converter_one_channel_pick,
    input wire logic [3:0]  converter_two_channel_pick
);
    wire [7:0] pk = {converter_two_channel_pick, converter_one_channel_pick};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("stray read data");
    a_rd_addr: assert property (reg_rd && (reg_addr == 6'h3B || reg_addr == 6'h3C)
        |=> reg_rdata[14:9] == $past(reg_addr)) else $error("bad address field");
    a_ret_once: assert property (return_to_first |=> !return_to_first)
        else $error("return held");
    a_ret_why: assert property (return_to_first |-> $past(conv_done) && !active_entry)
        else $error("bad return");
    a_pick_hold: assert property (!conv_done |=> $stable(pk))
        else $error("pick moved");
    a_entry_hold: assert property (!conv_done |=> $stable(active_entry))
        else $error("entry moved");
    a_wrap: assert property (conv_done && active_entry |=> !active_entry)
        else $error("no wrap");
    a_step: assert property (conv_done && !active_entry |=> active_entry != return_to_first)
        else $error("no step");
    c_ret: cover property (return_to_first);
    c_wrap: cover property (conv_done && active_entry);
    c_wr_rd: cover property (reg_wr ##2 reg_rd);
endmodule // sse_chk
`default_nettype wire

// ### verification/sse_conv.sv
// Conversion engine model: ends a conversion len cycles after start.
// Assumes start is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module sse_conv (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       start,
    input  wire logic [3:0] len,
    // Completion
    output var  logic       conv_done
);
    logic [3:0] cnt;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= cnt == 4'h1;
            cnt <= start ? len : cnt - {3'h0, cnt != 4'h0};
        end
    end
endmodule // sse_conv
`default_nettype wire

// ### verification/tb_top.sv
// Bench for the stack entries: register access and stepping.
// Assumes design, checker and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, start = 0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [3:0] len = 4'h1, pa, pb;
    logic [15:0] reg_rdata;
    logic conv_done, act, ret;
    int miscompares = 0, compares = 0;
    sse_stack u_dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .conv_done, .active_entry(act), .return_to_first(ret),
        .converter_one_channel_pick(pa), .converter_two_channel_pick(pb));
    sse_conv u_conv (.core_clk, .nrst, .start, .len, .conv_done);
    always #25 core_clk = ~core_clk;
    task chk(input logic [15:0] g, e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 if (!w) chk(reg_rdata, d);
    endtask
    task conv(input logic [3:0] n, input logic [15:0] e);
        @(posedge core_clk);
        start <= 1'b1;
        len <= n;
        @(posedge core_clk);
        start <= 1'b0;
        #1;
        for (int i = 0; conv_done !== 1'b1; i++) begin
            if (i > 20) conclude(1);
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1 chk({6'h00, ret, act, pb, pa}, e);
    endtask
    task conclude(input int t);
        miscompares += t;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        acc(0, 6'h3B, 16'h7600);
        acc(0, 6'h3C, 16'h7800);
        acc(0, 6'h00, 16'h0000);
        $display("reset test done");
        acc(1, 6'h3C, 16'hF9A5);
        acc(0, 6'h3C, 16'hF9A5);
        acc(1, 6'h3B, 16'hF612);
        acc(0, 6'h3B, 16'hF612);
        chk({8'h00, pb, pa}, 16'h0000);
        $display("write test done");
        conv(4'h1, 16'h01A5);
        conv(4'h5, 16'h0212);
        conv(4'h1, 16'h01A5);
        $display("step test done");
        conclude(0);
    end
endmodule // tb_top
bind sse_stack sse_chk u_chk (.core_clk, .nrst, .reg_rd, .reg_wr, .conv_done, .reg_addr,
    .reg_rdata, .active_entry, .return_to_first, .converter_one_channel_pick,
    .converter_two_channel_pick);
`default_nettype wire
